// ===== common/utxc_defines.vh
`ifndef UTXC_DEFINES_VH
`define UTXC_DEFINES_VH

// ==================================================
// Register byte offsets
`define UTXC_OFF_CTRL 8'h00
`define UTXC_OFF_STATUS 8'h04
`define UTXC_OFF_TXCOUNT 8'h08
`define UTXC_OFF_DIV_HS 8'h0C
`define UTXC_OFF_DIV_FS 8'h10
`define UTXC_OFF_DIV_LS 8'h14

// ==================================================
// Control register fields
`define UTXC_CTRL_HOST_BIT 0
`define UTXC_CTRL_TXEN_BIT 1
`define UTXC_CTRL_RST 2'h2

// ==================================================
// Status register fields
`define UTXC_ST_STATE_LSB 0
`define UTXC_ST_SUSP_BIT 4
`define UTXC_ST_TERM_BIT 5
`define UTXC_ST_SPEED_LSB 6
`define UTXC_ST_TXVALID_BIT 8

// ==================================================
// Byte slot divisor reset values, in aclk cycles
`define UTXC_DIV_HS_RST 16'h0001
`define UTXC_DIV_FS_RST 16'h0008
`define UTXC_DIV_LS_RST 16'h0040

// ==================================================
// Speed select encodings
`define UTXC_SPD_HS 2'h0
`define UTXC_SPD_FS 2'h1
`define UTXC_SPD_LS 2'h2
`define UTXC_SPD_LS_FSEDGE 2'h3

// ==================================================
// Line symbol kinds
`define UTXC_SYM_SYNC 2'h1
`define UTXC_SYM_DATA 2'h2
`define UTXC_SYM_EOP 2'h3

// ==================================================
// AXI responses
`define UTXC_RESP_OKAY 2'h0
`define UTXC_RESP_SLVERR 2'h2

// ==================================================
// Timing: clock period and receive latency bound
`define UTXC_CLK_PERIOD_PS 10000
`define UTXC_RX_LAT_MAX_PS 89583
`define UTXC_RX_LAT_CYC (`UTXC_RX_LAT_MAX_PS / `UTXC_CLK_PERIOD_PS)
`define UTXC_RX_PIPE 2

`endif

// ===== src/utxc_pacer.v
`timescale 1ns/100ps

// ==================================================
// Byte slot pacer: one-cycle tick every div cycles
module utxc_pacer
(
  input wire aclk,
  input wire rst,
  input wire run,
  input wire [15:0] div,
  output reg tick
);

  reg [15:0] cnt_r;

  // Divisor of zero acts as one so the pacer never stalls
  always @(posedge aclk)
  begin
    if (rst || !run)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end
    else if ((cnt_r + 16'h0001) >= div)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule

// ===== src/utxc_top.v
// Behaviour
// - The line speed follows the two-bit speed select, 00 high, 01 full, 10 low, 11 low data with full edges.
// - Termination select 0 enables high-speed terminations and 1 enables full-speed terminations.
// - Transmit ready pulses to say the current byte was taken and the next may follow.
// - Transmit valid high means the data bus holds a byte to send.
// - A rise of transmit valid starts a SYNC pattern on the line ahead of the data.
// - A fall of transmit valid starts an end-of-packet sequence on the line.
// - Suspend input low enters low-power suspend with clocks stopped, high is normal operation.
// - In host role the pull-up is removed in suspend, in device role the pull-down follows termination select.
// - The active-high reset pin returns every state machine to its start, and may arrive asynchronously; here the AXI channels reset only on aresetn.
// - Received bytes reach the data bus within 43 high-speed bit times.
// - A reference clock is sourced and every port signal is driven and sampled on it; here ports use aclk and ref_clock_out is aclk halved.
// - Bytes travel on one two-way eight-bit bus with bit 7 the most significant; here tx_data is an input and rx_data an output qualified by data_oe.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "utxc_defines.vh"

module utxc_top
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire port_reset,
  input wire suspend_n,
  input wire [1:0] speed_sel,
  input wire term_sel,
  input wire tx_valid,
  output reg tx_ready,
  input wire [7:0] tx_data,
  output reg [7:0] rx_data,
  output reg data_oe,
  output reg ref_clock_out,
  input wire [7:0] rx_line_byte,
  input wire rx_line_valid,
  output reg [1:0] line_speed,
  output reg line_fs_edges,
  output reg hs_term_en,
  output reg fs_term_en,
  output reg pullup_en,
  output reg pulldown_en,
  output reg low_power,
  output reg line_sym_valid,
  output reg [1:0] line_sym_kind,
  output reg [7:0] line_sym_byte
);

  // ==================================================
  // States
  localparam ST_IDLE = 4'b0001;
  localparam ST_SYNC = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_EOP = 4'b1000;

  // Slot divisor chosen by the speed select
  function [15:0] pick_div;
    input [1:0] spd;
    input [15:0] dhs;
    input [15:0] dfs;
    input [15:0] dls;
    begin
      case (spd)
        `UTXC_SPD_HS: pick_div = dhs;
        `UTXC_SPD_FS: pick_div = dfs;
        default: pick_div = dls;
      endcase
    end
  endfunction

  reg [1:0] ctrl_r;
  reg [15:0] div_hs_r;
  reg [15:0] div_fs_r;
  reg [15:0] div_ls_r;
  reg [31:0] txcount_r;
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [7:0] rx_pipe_r [0:`UTXC_RX_PIPE-1];
  reg [`UTXC_RX_PIPE-1:0] rx_vpipe_r;
  reg [1:0] rst_sync_r;
  reg [1:0] susp_sync_r;
  reg [1:0] txv_sync_r;
  reg [1:0] term_sync_r;
  reg [3:0] spd_sync_r;
  reg [15:0] data_sync_r;
  reg [7:0] rxb_sync1_r;
  reg [7:0] rxb_sync2_r;
  reg [1:0] rxv_sync_r;
  reg txv_prev_r;
  wire rst;
  wire txv;
  wire suspended;
  wire term_fs;
  wire [1:0] spd;
  wire [7:0] tx_byte;
  wire slot_tick;
  wire wr_fire;
  wire [31:0] wr_merged;
  wire wr_hit;
  wire ar_hit;
  wire sending;
  integer k;

  // ==================================================
  // Pin synchronisers, second stage only is read
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_sync_r <= 2'h3;
      susp_sync_r <= 2'h3;
      txv_sync_r <= 2'h0;
      term_sync_r <= 2'h0;
      spd_sync_r <= 4'h0;
      data_sync_r <= 16'h0000;
      rxb_sync1_r <= 8'h00;
      rxb_sync2_r <= 8'h00;
      rxv_sync_r <= 2'h0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], port_reset};
      susp_sync_r <= {susp_sync_r[0], suspend_n};
      txv_sync_r <= {txv_sync_r[0], tx_valid};
      term_sync_r <= {term_sync_r[0], term_sel};
      spd_sync_r <= {spd_sync_r[1:0], speed_sel};
      data_sync_r <= {data_sync_r[7:0], tx_data};
      rxb_sync1_r <= rx_line_byte;
      rxb_sync2_r <= rxb_sync1_r;
      rxv_sync_r <= {rxv_sync_r[0], rx_line_valid};
    end
  end

  assign rst = !aresetn || rst_sync_r[1];
  assign suspended = !susp_sync_r[1];
  assign term_fs = term_sync_r[1];
  assign spd = spd_sync_r[3:2];
  assign tx_byte = data_sync_r[15:8];
  assign txv = txv_sync_r[1] && ctrl_r[`UTXC_CTRL_TXEN_BIT];
  assign sending = (state_r != ST_IDLE);

  // ==================================================
  // Byte slot pacer, held cleared while suspended
  utxc_pacer u_pacer
  (
    .aclk(aclk),
    .rst(rst),
    .run(!suspended),
    .div(pick_div(spd, div_hs_r, div_fs_r, div_ls_r)),
    .tick(slot_tick)
  );

  // ==================================================
  // Transmit state machine
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (txv && !txv_prev_r)
          state_nxt = ST_SYNC;
      ST_SYNC:
        if (slot_tick)
          state_nxt = txv ? ST_DATA : ST_EOP;
      ST_DATA:
        if (slot_tick && !txv)
          state_nxt = ST_EOP;
      ST_EOP:
        if (slot_tick)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Suspend aborts a packet; the line is dead with clocks off
  always @(posedge aclk)
  begin
    if (rst || suspended)
    begin
      state_r <= ST_IDLE;
      txv_prev_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      txv_prev_r <= txv;
    end
  end

  // ==================================================
  // Line symbols and byte acknowledge
  always @(posedge aclk)
  begin
    if (rst || suspended)
    begin
      tx_ready <= 1'b0;
      line_sym_valid <= 1'b0;
      line_sym_kind <= 2'h0;
      line_sym_byte <= 8'h00;
      txcount_r <= 32'h0;
    end
    else
    begin
      tx_ready <= 1'b0;
      line_sym_valid <= 1'b0;
      if (state_r == ST_SYNC && slot_tick)
      begin
        line_sym_valid <= 1'b1;
        line_sym_kind <= `UTXC_SYM_SYNC;
      end
      else if (state_r == ST_DATA && slot_tick && txv)
      begin
        tx_ready <= 1'b1;
        line_sym_valid <= 1'b1;
        line_sym_kind <= `UTXC_SYM_DATA;
        line_sym_byte <= tx_byte;
        txcount_r <= txcount_r + 32'h1;
      end
      else if (state_r == ST_EOP && slot_tick)
      begin
        line_sym_valid <= 1'b1;
        line_sym_kind <= `UTXC_SYM_EOP;
      end
    end
  end

  // ==================================================
  // Line setup: speed, terminations, pulls, power
  always @(posedge aclk)
  begin
    if (rst)
    begin
      line_speed <= `UTXC_SPD_HS;
      line_fs_edges <= 1'b0;
      hs_term_en <= 1'b1;
      fs_term_en <= 1'b0;
      pullup_en <= 1'b0;
      pulldown_en <= 1'b0;
      low_power <= 1'b0;
      ref_clock_out <= 1'b0;
    end
    else
    begin
      line_speed <= spd;
      line_fs_edges <= (spd == `UTXC_SPD_LS_FSEDGE) || (spd == `UTXC_SPD_FS);
      hs_term_en <= !term_fs;
      fs_term_en <= term_fs;
      pullup_en <= ctrl_r[`UTXC_CTRL_HOST_BIT] && !suspended;
      pulldown_en <= !ctrl_r[`UTXC_CTRL_HOST_BIT] && term_fs;
      low_power <= suspended;
      ref_clock_out <= suspended ? 1'b0 : !ref_clock_out;
    end
  end

  // ==================================================
  // Receive path onto the shared data bus
  always @(posedge aclk)
  begin
    if (rst)
    begin
      for (k = 0; k < `UTXC_RX_PIPE; k = k + 1)
        rx_pipe_r[k] <= 8'h00;
      rx_vpipe_r <= {`UTXC_RX_PIPE{1'b0}};
      rx_data <= 8'h00;
      data_oe <= 1'b0;
    end
    else
    begin
      rx_pipe_r[0] <= rxb_sync2_r;
      rx_vpipe_r[0] <= rxv_sync_r[1] && !sending && !suspended;
      for (k = 1; k < `UTXC_RX_PIPE; k = k + 1)
      begin
        rx_pipe_r[k] <= rx_pipe_r[k-1];
        rx_vpipe_r[k] <= rx_vpipe_r[k-1];
      end
      // bus driven only when not sending
      rx_data <= rx_pipe_r[`UTXC_RX_PIPE-1];
      data_oe <= rx_vpipe_r[`UTXC_RX_PIPE-1] && !sending;
    end
  end

  // ==================================================
  // AXI4-Lite write channel, address and data in any order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_merged = {wstrb_r[3] ? wdata_r[31:24] : 8'h00, wstrb_r[2] ? wdata_r[23:16] : 8'h00,
                      wstrb_r[1] ? wdata_r[15:8] : 8'h00, wstrb_r[0] ? wdata_r[7:0] : 8'h00};
  assign wr_hit = (awaddr_r == `UTXC_OFF_CTRL) || (awaddr_r == `UTXC_OFF_DIV_HS) ||
                  (awaddr_r == `UTXC_OFF_DIV_FS) || (awaddr_r == `UTXC_OFF_DIV_LS) ||
                  (awaddr_r == `UTXC_OFF_STATUS) || (awaddr_r == `UTXC_OFF_TXCOUNT);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UTXC_RESP_OKAY;
      ctrl_r <= `UTXC_CTRL_RST;
      div_hs_r <= `UTXC_DIV_HS_RST;
      div_fs_r <= `UTXC_DIV_FS_RST;
      div_ls_r <= `UTXC_DIV_LS_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `UTXC_RESP_OKAY : `UTXC_RESP_SLVERR;
        // Partial strobes update only the lanes written
        case (awaddr_r)
          `UTXC_OFF_CTRL: if (wstrb_r[0]) ctrl_r <= wr_merged[1:0];
          `UTXC_OFF_DIV_HS: div_hs_r <= (wr_merged[15:0] & {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}}) |
                                        (div_hs_r & ~{{8{wstrb_r[1]}}, {8{wstrb_r[0]}}});
          `UTXC_OFF_DIV_FS: div_fs_r <= (wr_merged[15:0] & {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}}) |
                                        (div_fs_r & ~{{8{wstrb_r[1]}}, {8{wstrb_r[0]}}});
          `UTXC_OFF_DIV_LS: div_ls_r <= (wr_merged[15:0] & {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}}) |
                                        (div_ls_r & ~{{8{wstrb_r[1]}}, {8{wstrb_r[0]}}});
          default: ;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_hit = ({s_axi_araddr[7:2], 2'h0} <= `UTXC_OFF_DIV_LS);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `UTXC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ar_hit ? `UTXC_RESP_OKAY : `UTXC_RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'h0})
        `UTXC_OFF_CTRL: s_axi_rdata <= {30'h0, ctrl_r};
        `UTXC_OFF_STATUS: s_axi_rdata <= {23'h0, txv_sync_r[1], spd, term_fs, suspended, state_r};
        `UTXC_OFF_TXCOUNT: s_axi_rdata <= txcount_r;
        `UTXC_OFF_DIV_HS: s_axi_rdata <= {16'h0, div_hs_r};
        `UTXC_OFF_DIV_FS: s_axi_rdata <= {16'h0, div_fs_r};
        `UTXC_OFF_DIV_LS: s_axi_rdata <= {16'h0, div_ls_r};
        default: s_axi_rdata <= 32'h0;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// ===== bench/utxc_top_chk.sv
`timescale 1ns/100ps
`include "utxc_defines.vh"

// ==================================================
// Port checker for the transmit control port
module utxc_chk
(
  input wire aclk,
  input wire aresetn,
  input wire port_reset,
  input wire suspend_n,
  input wire [1:0] speed_sel,
  input wire term_sel,
  input wire tx_valid,
  input wire tx_ready,
  input wire data_oe,
  input wire ref_clock_out,
  input wire rx_line_valid,
  input wire [1:0] line_speed,
  input wire line_fs_edges,
  input wire hs_term_en,
  input wire fs_term_en,
  input wire pullup_en,
  input wire low_power,
  input wire line_sym_valid,
  input wire [1:0] line_sym_kind
);
  reg [3:0] quiet_r;
  reg [1:0] last_r;
  wire ok = quiet_r == 4'hF;
  wire sym_data = line_sym_valid && line_sym_kind == `UTXC_SYM_DATA;
  wire last_pkt = last_r == `UTXC_SYM_SYNC || last_r == `UTXC_SYM_DATA;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Settle count, since the pin synchronisers lag any reset
  always @(posedge aclk)
    if (!aresetn || port_reset)
      quiet_r <= 4'h0;
    else if (!ok)
      quiet_r <= quiet_r + 4'h1;

  // Last symbol kind; forgotten while settling or suspended, as those abort a packet
  always @(posedge aclk)
    if (!aresetn || !ok || low_power)
      last_r <= 2'h0;
    else if (line_sym_valid)
      last_r <= line_sym_kind;

  speed_follow_a:
    assert property (ok && $stable(speed_sel)[*5] |-> line_speed == speed_sel && line_fs_edges == speed_sel[0])
    else $error("line speed does not follow select");
  term_follow_a:
    assert property (ok && !low_power && $stable(term_sel)[*5] |-> hs_term_en == !term_sel && fs_term_en == term_sel)
    else $error("terminations do not follow select");
  suspend_stops_a:
    assert property (ok && !suspend_n[*5] |-> low_power && !ref_clock_out)
    else $error("suspend not entered");
  pullup_off_a:
    assert property (low_power |-> !pullup_en)
    else $error("pull-up kept in suspend");
  ready_with_data_a:
    assert property (tx_ready |-> sym_data)
    else $error("ready without a data byte");
  data_after_sync_a:
    assert property (ok && sym_data |-> last_pkt)
    else $error("data byte without sync");
  eop_closes_a:
    assert property (ok && line_sym_valid && line_sym_kind == `UTXC_SYM_EOP |-> last_pkt && !$past(tx_valid, 2))
    else $error("end of packet out of place");
  reset_quiets_a:
    assert property (port_reset[*5] |-> !line_sym_valid && !tx_ready && !data_oe)
    else $error("activity during pin reset");
  rx_latency_a:
    assert property (ok && suspend_n && $rose(rx_line_valid) |-> ##[1:8] data_oe)
    else $error("receive byte too late");
endmodule

bind utxc_top utxc_chk u_chk
(
  .aclk(aclk), .aresetn(aresetn), .port_reset(port_reset), .suspend_n(suspend_n), .speed_sel(speed_sel),
  .term_sel(term_sel), .tx_valid(tx_valid), .tx_ready(tx_ready), .data_oe(data_oe),
  .ref_clock_out(ref_clock_out), .rx_line_valid(rx_line_valid), .line_speed(line_speed),
  .line_fs_edges(line_fs_edges), .hs_term_en(hs_term_en), .fs_term_en(fs_term_en), .pullup_en(pullup_en),
  .low_power(low_power), .line_sym_valid(line_sym_valid), .line_sym_kind(line_sym_kind)
);

// ===== bench/utxc_link_model.sv
`timescale 1ns/100ps

// ==================================================
// Link controller model on the far side of the port
module utxc_link_model
(
  input wire aclk,
  input wire tx_ready,
  output logic port_reset,
  output logic suspend_n,
  output logic [1:0] speed_sel,
  output logic term_sel,
  output logic tx_valid,
  output logic [7:0] tx_data
);
  // Start in reset; an idle bus sits at its pull-low level
  initial
  begin
    port_reset = 1'b1;
    suspend_n = 1'b1;
    speed_sel = 2'h0;
    term_sel = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
  end

  // release on an edge, then far more than five quiet edges
  task pin_reset();
    port_reset <= 1'b1;
    repeat (8) @(posedge aclk);
    port_reset <= 1'b0;
    repeat (20) @(posedge aclk);
  endtask

  task set_ctrl(input logic [1:0] spd, input logic term, input logic sus_n);
    speed_sel <= spd;
    term_sel <= term;
    suspend_n <= sus_n;
    repeat (8) @(posedge aclk);
  endtask

  // byte held until taken; a reset or long stall gives up
  task send(input int n, input logic [7:0] b0, input int wmax);
    int k;
    int w;
    k = 0;
    w = 0;
    tx_valid <= 1'b1;
    while (k < n && w < wmax && !port_reset)
    begin
      tx_data <= b0 + k[7:0];
      @(posedge aclk);
      w++;
      // ready only counts inside a packet
      if (tx_ready)
        k++;
    end
    tx_valid <= 1'b0;
    tx_data <= 8'h00;
    repeat (40) @(posedge aclk);
  endtask
endmodule

// ===== bench/utxc_top_bench.sv
`timescale 1ns/100ps
`include "utxc_defines.vh"

// ==================================================
// Bench for the transmit control port
module utxc_top_bench;
  localparam logic [1:0] OK = `UTXC_RESP_OKAY;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rx_line_valid, r0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx_line_byte;
  logic [31:0] s_axi_wdata;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_ready, data_oe, ref_clock_out;
  wire [1:0] s_axi_bresp, s_axi_rresp, line_speed, speed_sel, line_sym_kind;
  wire [31:0] s_axi_rdata;
  wire [7:0] rx_data, tx_data, line_sym_byte;
  wire port_reset, suspend_n, term_sel, tx_valid, line_fs_edges, hs_term_en, fs_term_en, pullup_en, pulldown_en;
  wire low_power, line_sym_valid;
  int n_errors = 0;
  int total_checks = 0;
  int divs [4] = '{6, 8, 12, 12};
  int i, w;
  logic [1:0] kinds [$];
  logic [7:0] bytes [$];
  time last_t, gap_t;

  utxc_top dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_reset(port_reset), .suspend_n(suspend_n), .speed_sel(speed_sel), .term_sel(term_sel),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_data(rx_data), .data_oe(data_oe),
    .ref_clock_out(ref_clock_out), .rx_line_byte(rx_line_byte), .rx_line_valid(rx_line_valid),
    .line_speed(line_speed), .line_fs_edges(line_fs_edges), .hs_term_en(hs_term_en), .fs_term_en(fs_term_en),
    .pullup_en(pullup_en), .pulldown_en(pulldown_en), .low_power(low_power), .line_sym_valid(line_sym_valid),
    .line_sym_kind(line_sym_kind), .line_sym_byte(line_sym_byte)
  );

  utxc_link_model link
  (
    .aclk(aclk), .tx_ready(tx_ready), .port_reset(port_reset), .suspend_n(suspend_n), .speed_sel(speed_sel),
    .term_sel(term_sel), .tx_valid(tx_valid), .tx_data(tx_data)
  );

  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Line symbol log; the gap between data bytes gives the byte slot
  always @(posedge aclk)
    if (line_sym_valid === 1'b1)
    begin
      kinds.push_back(line_sym_kind);
      if (line_sym_kind == `UTXC_SYM_DATA)
      begin
        bytes.push_back(line_sym_byte);
        gap_t = $time - last_t;
        last_t = $time;
      end
    end

  // Compare one value; the case inequality lets no unknown slip through
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, wv, bd;
    aw = 1'b1;
    wv = 1'b1;
    bd = 1'b0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bd && w < 100)
    begin
      @(posedge aclk);
      w++;
      if (!aw && !wv && s_axi_bvalid === 1'b1)
      begin
        bd = 1'b1;
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
      end
      if (aw && s_axi_awready === 1'b1)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wv && s_axi_wready === 1'b1)
      begin
        wv = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    check(bd, 1'b1);
    @(posedge aclk);
  endtask

  // Read: address held until taken, data taken at the edge rvalid is seen
  task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, rd;
    ar = 1'b1;
    rd = 1'b0;
    w = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rd && w < 100)
    begin
      @(posedge aclk);
      w++;
      if (!ar && s_axi_rvalid === 1'b1)
      begin
        rd = 1'b1;
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed);
        check(s_axi_rresp, er);
      end
      if (ar && s_axi_arready === 1'b1)
      begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    check(rd, 1'b1);
    @(posedge aclk);
  endtask

  // One packet at the current speed, then its symbols
  task pkt(input int n, input logic [7:0] b0, input int div);
    kinds.delete();
    bytes.delete();
    link.send(n, b0, 2000);
    check(kinds.size(), n + 2);
    check(kinds[0], `UTXC_SYM_SYNC);
    check(kinds[n + 1], `UTXC_SYM_EOP);
    for (int k = 0; k < n; k++)
      check(bytes[k], b0 + k[7:0]);
    check(32'(gap_t / 10), div);
  endtask

  // Single place where the run ends
  task tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog at 10000 cycles, over ten times the cycles the tests need
  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    rx_line_valid = 1'b0;
    rx_line_byte = 8'h00;
    last_t = 0;
    gap_t = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    link.pin_reset();
    axi_rd(`UTXC_OFF_CTRL, 32'h2, OK);
    axi_rd(`UTXC_OFF_DIV_FS, 32'h8, OK);
    axi_rd(`UTXC_OFF_DIV_LS, 32'h40, OK);
    axi_wr(`UTXC_OFF_DIV_HS, 32'h6, OK);
    axi_wr(`UTXC_OFF_DIV_LS, 32'hC, OK);
    axi_wr(8'h18, 32'h5, `UTXC_RESP_SLVERR);
    axi_rd(8'h18, 32'h0, `UTXC_RESP_SLVERR);
    for (i = 0; i < 4; i++)
    begin
      link.set_ctrl(i[1:0], 1'b0, 1'b1);
      check(line_speed, i);
      check(line_fs_edges, i[0]);
      pkt(3, 8'hC0 + i[7:0], divs[i]);
      axi_rd(`UTXC_OFF_TXCOUNT, 3 * i + 3, OK);
    end
    for (i = 0; i < 2; i++)
    begin
      link.set_ctrl(2'h1, i[0], 1'b1);
      check(hs_term_en, !i[0]);
      check(fs_term_en, i[0]);
      check(pulldown_en, i[0]);
    end
    // Transmit disabled: a packet offered by the link must not reach the line
    axi_wr(`UTXC_OFF_CTRL, 32'h1, OK);
    kinds.delete();
    link.send(1, 8'h66, 60);
    check(kinds.size(), 0);
    axi_wr(`UTXC_OFF_CTRL, 32'h3, OK);
    repeat (2) @(posedge aclk);
    check(pullup_en, 1'b1);
    link.set_ctrl(2'h1, 1'b1, 1'b0);
    check(low_power, 1'b1);
    check(pullup_en, 1'b0);
    check(ref_clock_out, 1'b0);
    kinds.delete();
    link.send(1, 8'h55, 60);
    check(kinds.size(), 0);
    link.set_ctrl(2'h1, 1'b1, 1'b1);
    axi_rd(`UTXC_OFF_TXCOUNT, 32'h0, OK);
    r0 = ref_clock_out;
    @(posedge aclk);
    check(ref_clock_out, !r0);
    rx_line_byte <= 8'h1D;
    rx_line_valid <= 1'b1;
    w = 0;
    while (data_oe !== 1'b1 && w < 20)
    begin
      @(posedge aclk);
      w++;
    end
    check(w <= 8, 1'b1);
    check(rx_data, 8'h1D);
    rx_line_valid <= 1'b0;
    // Pin reset lands in the middle of a packet
    fork
      link.send(4, 8'h30, 2000);
      begin
        repeat (20) @(posedge aclk);
        link.pin_reset();
      end
    join
    axi_rd(`UTXC_OFF_STATUS, 32'h61, OK);
    axi_rd(`UTXC_OFF_TXCOUNT, 32'h0, OK);
    tally_and_finish();
  end
endmodule
